// ### shared/sgcb_map.svh
`ifndef SGCB_MAP_SVH
`define SGCB_MAP_SVH
// Register offsets
`define SGCB_ADDR_FAMILY    8'h00
`define SGCB_ADDR_PART_RUN  8'h01
`define SGCB_ADDR_GCTL0     8'h02
// Field positions
`define SGCB_RUN_BIT        0
`define SGCB_REV_LSB        1
`define SGCB_PART_LSB       4
`define SGCB_BACKOFF_BIT    7
`define SGCB_SOFTRST_BIT    6
`define SGCB_LPURGE_BIT     5
`define SGCB_FPURGE_BIT     4
`define SGCB_POLICY_BIT     1
`define SGCB_LINKAGE_BIT    0
// Reset values and masks
`define SGCB_RUN_RST        1'b1
`define SGCB_GCTL0_RST      8'h0C
`define SGCB_GCTL0_RSVD     8'h0C
`define SGCB_GCTL0_RW_MASK  8'hC3
// Serial management commands
`define SGCB_SPI_CMD_RD     8'h03
`define SGCB_SPI_CMD_WR     8'h02
// Frame classification
`define SGCB_PAUSE_TYPE     16'h8808
`define SGCB_PAUSE_DA       48'h0180_C200_0001
// Timing
`define SGCB_CLK_PERIOD_NS  4
`define SGCB_NS_PER_S       64'h0000_0000_3B9A_CA00
`define SGCB_AGE_PERIOD_S   300
`define SGCB_AGE_TOL_S      75
`define SGCB_FAST_AGE_MAX_US 800
// Sizes
`define SGCB_IDX_W          10
`define SGCB_AGE_CNT_W      40
`define SGCB_NPORTS         5
`endif

// ### shared/sgcb_pkg.sv
`include "sgcb_map.svh"
package sgcb_pkg;
  typedef enum logic [2:0] {
    SGCB_OP_NONE,
    SGCB_OP_LEARNED,
    SGCB_OP_FIXED,
    SGCB_OP_FAST_AGE,
    SGCB_OP_AGE
  } sgcb_op_t;

  typedef enum logic [1:0] {SGCB_PH_CMD, SGCB_PH_ADDR, SGCB_PH_DATA} sgcb_spi_phase_t;

  typedef enum logic [1:0] {SGCB_ENG_IDLE, SGCB_ENG_WAIT, SGCB_ENG_EVAL, SGCB_ENG_NEXT} sgcb_eng_state_t;

  typedef struct packed {
    logic                        valid;
    logic                        fixed;
    logic                        unicast;
    logic                        stale;
    logic [2:0]                  port;
    logic [`SGCB_NPORTS-1:0]     fwd_ports;
  } sgcb_entry_t;

  typedef struct packed {
    logic                        rd_en;
    logic                        rd_fixed;
    logic                        del;
    logic                        mark_stale;
    logic [`SGCB_IDX_W-1:0]      idx;
  } sgcb_tbl_cmd_t;

  typedef struct packed {
    logic [15:0]                 ethertype;
    logic [47:0]                 da;
    logic                        pause_qual;
  } sgcb_frame_t;
endpackage

// ### rtl/sgcb_purge_engine.sv
`timescale 1ns/10ps
`include "sgcb_map.svh"
module sgcb_purge_engine #(
  parameter int LEARN_DEPTH = 1024,
  parameter int FIXED_DEPTH = 32
) (
  input  wire logic                    clk_sys,   // System clock
  input  wire logic                    rst,       // Hard or soft reset
  input  wire logic                    start,     // Start a pass
  input  sgcb_pkg::sgcb_op_t           op,        // Pass kind
  input  wire logic [`SGCB_NPORTS-1:0] learn_dis, // Per-port learning disabled
  input  sgcb_pkg::sgcb_entry_t        entry,     // Entry read back
  output logic                         busy,      // Pass running
  output logic                         done,      // Pass finished
  output sgcb_pkg::sgcb_tbl_cmd_t      cmd        // Table commands
);
  localparam logic [`SGCB_IDX_W-1:0] LAST_L = `SGCB_IDX_W'(LEARN_DEPTH - 1);
  localparam logic [`SGCB_IDX_W-1:0] LAST_F = `SGCB_IDX_W'(FIXED_DEPTH - 1);

  sgcb_pkg::sgcb_eng_state_t state_r;
  sgcb_pkg::sgcb_op_t        op_r;
  logic [`SGCB_IDX_W-1:0]    last_idx;

  function automatic logic single_port(input logic [`SGCB_NPORTS-1:0] f);
    return (f != '0) && ((f & (f - `SGCB_NPORTS'(1))) == '0);
  endfunction

  function automatic logic del_hit(input sgcb_pkg::sgcb_op_t o, input sgcb_pkg::sgcb_entry_t e,
                                   input logic [`SGCB_NPORTS-1:0] ld);
    logic own_dis;
    own_dis = (e.port < 3'(`SGCB_NPORTS)) && ld[e.port];
    case (o)
      sgcb_pkg::SGCB_OP_LEARNED:  return e.valid && !e.fixed && own_dis;       // [R5] [R6]
      sgcb_pkg::SGCB_OP_FIXED:    return e.valid && e.fixed && e.unicast &&
                                         single_port(e.fwd_ports) &&
                                         ((e.fwd_ports & ld) != '0);           // [R7] [R8]
      sgcb_pkg::SGCB_OP_FAST_AGE: return e.valid && !e.fixed;                  // [R13]
      sgcb_pkg::SGCB_OP_AGE:      return e.valid && !e.fixed && e.stale;
      default:                    return 1'b0;
    endcase
  endfunction

  assign last_idx = (op_r == sgcb_pkg::SGCB_OP_FIXED) ? LAST_F : LAST_L;
  assign busy     = (state_r != sgcb_pkg::SGCB_ENG_IDLE);

  // Three cycles per entry: read, wait for data, decide
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= sgcb_pkg::SGCB_ENG_IDLE;
      op_r    <= sgcb_pkg::SGCB_OP_NONE;
      cmd     <= '0;
      done    <= 1'b0;
    end else begin
      done           <= 1'b0;
      cmd.rd_en      <= 1'b0;
      cmd.del        <= 1'b0;
      cmd.mark_stale <= 1'b0;
      case (state_r)
        sgcb_pkg::SGCB_ENG_IDLE: begin
          if (start) begin
            op_r         <= op;
            cmd.idx      <= '0;
            cmd.rd_fixed <= (op == sgcb_pkg::SGCB_OP_FIXED);
            cmd.rd_en    <= 1'b1;
            state_r      <= sgcb_pkg::SGCB_ENG_WAIT;
          end
        end
        sgcb_pkg::SGCB_ENG_WAIT: begin
          state_r <= sgcb_pkg::SGCB_ENG_EVAL;
        end
        sgcb_pkg::SGCB_ENG_EVAL: begin
          cmd.del        <= del_hit(op_r, entry, learn_dis);
          cmd.mark_stale <= (op_r == sgcb_pkg::SGCB_OP_AGE) && entry.valid && !entry.fixed && !entry.stale;
          if (cmd.idx == last_idx) begin
            done    <= 1'b1;                                                   // [R5] [R7]
            state_r <= sgcb_pkg::SGCB_ENG_IDLE;
          end else begin
            state_r <= sgcb_pkg::SGCB_ENG_NEXT;
          end
        end
        sgcb_pkg::SGCB_ENG_NEXT: begin
          cmd.idx   <= cmd.idx + `SGCB_IDX_W'(1);
          cmd.rd_en <= 1'b1;
          state_r   <= sgcb_pkg::SGCB_ENG_WAIT;
        end
        default: begin
          state_r <= sgcb_pkg::SGCB_ENG_IDLE;
        end
      endcase
    end
  end
endmodule

// ### rtl/sgcb_top.sv
// Overview of operation
// R1: Bit 0 of the run register lets the fabric forward when one and halts it when zero, and resets to one.
// R2: Control bit 6 resets all operational state machines and the data path and holds them while it stays set.
// R3: The soft reset leaves every configuration register at its programmed value.
// R4: While the soft reset is set, no incoming packet is accepted.
// R5: Writing one to control bit 5 starts a purge of the learned table and the bit clears when it is done.
// R6: That purge removes only learned entries whose port has learning disabled.
// R7: Writing one to control bit 4 starts a purge of the fixed table and the bit clears when it is done.
// R8: A fixed entry is purged only if it is unicast and names exactly one forwarding port with learning disabled.
// R9: With the drop policy bit at one, frames of type 0x8808 or to 01-80-C2-00-00-01 are dropped.
// R10: With the drop policy bit at zero, only frames qualified as pause frames are dropped.
// R11: With link-loss ageing set, a link going down starts one fast ageing pass finishing under 800 us.
// R12: After a fast pass the ageing timer returns to its normal 300 s period, within 75 s.
// R13: In link-loss ageing mode a lost link ages out every learned address.
// R14: Control bit 7 selects the alternative back-off when set and resets to zero.
// R15: The host reaches all registers of the 0x00 to 0xFF space over the serial management port.
// R16: Software waits for a purge bit to read zero before another purge or a learning change.
`timescale 1ns/10ps
`include "sgcb_map.svh"
module sgcb_top #(
  parameter logic [7:0]      FAMILY_CODE    = 8'h5A, // Arbitrary value
  parameter logic [3:0]      PART_CODE      = 4'h3,  // Arbitrary value
  parameter logic [2:0]      REV_CODE       = 3'h2,  // Arbitrary value
  parameter int              LEARN_DEPTH    = 1024,
  parameter int              FIXED_DEPTH    = 32,
  parameter longint unsigned AGE_PERIOD_CYC = `SGCB_AGE_PERIOD_S * `SGCB_NS_PER_S / `SGCB_CLK_PERIOD_NS
) (
  input  wire logic                    clk_sys,     // System clock
  input  wire logic                    sys_rst,     // Synchronous reset
  input  wire logic                    spi_sclk,    // Serial clock pin
  input  wire logic                    spi_cs_n,    // Chip select pin
  input  wire logic                    spi_mosi,    // Serial data in
  output logic                         spi_miso,    // Serial data out
  output logic                         spi_miso_oe, // Data out drive enable
  input  wire logic [`SGCB_NPORTS-1:0] link_up,     // Per-port link pins
  input  wire logic [`SGCB_NPORTS-1:0] learn_dis,   // Per-port learning disabled
  input  wire logic                    frm_valid,   // Frame header valid
  input  sgcb_pkg::sgcb_frame_t        frm,         // Frame header fields
  output logic                         frm_done,    // Verdict valid
  output logic                         frm_drop,    // Verdict drop
  output logic                         switch_run,  // Fabric forwarding enable
  output logic                         fabric_rst,  // Fabric reset
  output logic                         rx_accept,   // Ingress accept
  output logic                         backoff_alt, // Alternative back-off
  output sgcb_pkg::sgcb_tbl_cmd_t      tbl_cmd,     // Table commands
  input  sgcb_pkg::sgcb_entry_t        tbl_entry    // Table read data
);
  localparam logic [`SGCB_AGE_CNT_W-1:0] AGE_RELOAD = `SGCB_AGE_CNT_W'(AGE_PERIOD_CYC - 64'd1);

  // Synchronisers
  logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
  logic cs_s1_r, cs_s2_r;
  logic mosi_s1_r, mosi_s2_r;
  logic [`SGCB_NPORTS-1:0] link_s1_r, link_s2_r, link_prev_r;

  // Serial port
  sgcb_pkg::sgcb_spi_phase_t phase_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] rx_r, rx_nxt, tx_r, addr_r, addr_nxt;
  logic       is_rd_r, is_wr_r;
  logic       wr_stb_r;
  logic [7:0] wr_addr_r, wr_data_r;
  logic       sclk_rise, sclk_fall;

  // Registers
  logic       run_r;
  logic [7:0] gctl_r;
  logic       lpurge_r, fpurge_r, fast_pend_r, age_pend_r;
  logic       soft_rst;

  // Engine
  sgcb_pkg::sgcb_op_t run_op_r, sel_op_r;
  logic       start_r;
  logic       eng_busy, eng_done, eng_rst;
  logic [`SGCB_AGE_CNT_W-1:0] age_cnt_r;
  logic       link_fall, age_tick;
  logic       wr_gctl, wr_run;

  function automatic logic [7:0] reg_read(input logic [7:0] a);
    case (a)
      `SGCB_ADDR_FAMILY:   return FAMILY_CODE;
      `SGCB_ADDR_PART_RUN: return {PART_CODE, REV_CODE, run_r};
      `SGCB_ADDR_GCTL0:    return gctl_r | (8'(lpurge_r) << `SGCB_LPURGE_BIT) | (8'(fpurge_r) << `SGCB_FPURGE_BIT);
      default:             return 8'h00;
    endcase
  endfunction

  assign soft_rst  = gctl_r[`SGCB_SOFTRST_BIT];
  assign sclk_rise = sclk_s2_r && !sclk_s3_r;
  assign sclk_fall = !sclk_s2_r && sclk_s3_r;
  assign rx_nxt    = {rx_r[6:0], mosi_s2_r};
  assign addr_nxt  = addr_r + 8'h01;
  assign wr_gctl   = wr_stb_r && (wr_addr_r == `SGCB_ADDR_GCTL0);
  assign wr_run    = wr_stb_r && (wr_addr_r == `SGCB_ADDR_PART_RUN);
  assign link_fall = |(link_prev_r & ~link_s2_r);
  assign age_tick  = (age_cnt_r == '0);
  assign eng_rst   = sys_rst || soft_rst;                                      // [R2]

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      cs_s1_r   <= 1'b1;
      cs_s2_r   <= 1'b1;
      mosi_s1_r <= 1'b0;
      mosi_s2_r <= 1'b0;
    end else begin
      sclk_s1_r <= spi_sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      cs_s1_r   <= spi_cs_n;
      cs_s2_r   <= cs_s1_r;
      mosi_s1_r <= spi_mosi;
      mosi_s2_r <= mosi_s1_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      link_s1_r   <= '0;
      link_s2_r   <= '0;
      link_prev_r <= '0;
    end else begin
      link_s1_r   <= link_up;
      link_s2_r   <= link_s1_r;
      link_prev_r <= link_s2_r;
    end
  end

  // Command byte, address byte, then data bytes with address increment
  always_ff @(posedge clk_sys) begin                                           // [R15]
    if (sys_rst || cs_s2_r) begin
      phase_r   <= sgcb_pkg::SGCB_PH_CMD;
      bit_cnt_r <= 3'h0;
      rx_r      <= 8'h00;
      tx_r      <= 8'h00;
      addr_r    <= 8'h00;
      is_rd_r   <= 1'b0;
      is_wr_r   <= 1'b0;
      wr_stb_r  <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
      spi_miso  <= 1'b0;
    end else begin
      wr_stb_r <= 1'b0;
      if (sclk_rise) begin
        rx_r      <= rx_nxt;
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (bit_cnt_r == 3'h7) begin
          case (phase_r)
            sgcb_pkg::SGCB_PH_CMD: begin
              is_rd_r <= (rx_nxt == `SGCB_SPI_CMD_RD);
              is_wr_r <= (rx_nxt == `SGCB_SPI_CMD_WR);
              phase_r <= sgcb_pkg::SGCB_PH_ADDR;
            end
            sgcb_pkg::SGCB_PH_ADDR: begin
              addr_r  <= rx_nxt;
              tx_r    <= reg_read(rx_nxt);
              phase_r <= sgcb_pkg::SGCB_PH_DATA;
            end
            sgcb_pkg::SGCB_PH_DATA: begin
              if (is_wr_r) begin
                wr_stb_r  <= 1'b1;
                wr_addr_r <= addr_r;
                wr_data_r <= rx_nxt;
              end
              addr_r <= addr_nxt;
              tx_r   <= reg_read(addr_nxt);
            end
            default: begin
              phase_r <= sgcb_pkg::SGCB_PH_CMD;
            end
          endcase
        end
      end else if (sclk_fall && is_rd_r && (phase_r == sgcb_pkg::SGCB_PH_DATA)) begin
        spi_miso <= tx_r[7];
        tx_r     <= {tx_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= !cs_s2_r;
    end
  end

  // Configuration is cleared only by the hard reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      run_r  <= `SGCB_RUN_RST;                                                 // [R1]
      gctl_r <= `SGCB_GCTL0_RST;                                               // [R14]
    end else begin
      if (wr_run) begin
        run_r <= wr_data_r[`SGCB_RUN_BIT];                                     // [R1]
      end
      if (wr_gctl) begin
        gctl_r <= (wr_data_r & `SGCB_GCTL0_RW_MASK) | `SGCB_GCTL0_RSVD;        // [R3] [R14]
      end
    end
  end

  // Purge bits read one until their pass ends; a new set beats the clear
  always_ff @(posedge clk_sys) begin
    if (eng_rst) begin
      lpurge_r <= 1'b0;
    end else if (wr_gctl && wr_data_r[`SGCB_LPURGE_BIT]) begin
      lpurge_r <= 1'b1;                                                        // [R5]
    end else if (eng_done && (run_op_r == sgcb_pkg::SGCB_OP_LEARNED)) begin
      lpurge_r <= 1'b0;                                                        // [R5]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (eng_rst) begin
      fpurge_r <= 1'b0;
    end else if (wr_gctl && wr_data_r[`SGCB_FPURGE_BIT]) begin
      fpurge_r <= 1'b1;                                                        // [R7]
    end else if (eng_done && (run_op_r == sgcb_pkg::SGCB_OP_FIXED)) begin
      fpurge_r <= 1'b0;                                                        // [R7]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (eng_rst) begin
      fast_pend_r <= 1'b0;
    end else if (link_fall && gctl_r[`SGCB_LINKAGE_BIT]) begin
      fast_pend_r <= 1'b1;                                                     // [R11] [R13]
    end else if (eng_done && (run_op_r == sgcb_pkg::SGCB_OP_FAST_AGE)) begin
      fast_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (eng_rst) begin
      age_pend_r <= 1'b0;
    end else if (age_tick) begin
      age_pend_r <= 1'b1;
    end else if (eng_done && (run_op_r == sgcb_pkg::SGCB_OP_AGE)) begin
      age_pend_r <= 1'b0;
    end
  end

  // Normal ageing period, restarted after each fast pass
  always_ff @(posedge clk_sys) begin
    if (eng_rst) begin
      age_cnt_r <= AGE_RELOAD;
    end else if (eng_done && (run_op_r == sgcb_pkg::SGCB_OP_FAST_AGE)) begin
      age_cnt_r <= AGE_RELOAD;                                                 // [R12]
    end else if (age_tick) begin
      age_cnt_r <= AGE_RELOAD;                                                 // [R12]
    end else begin
      age_cnt_r <= age_cnt_r - `SGCB_AGE_CNT_W'(1);
    end
  end

  // One pass at a time: learned, fixed, fast ageing, normal ageing
  always_ff @(posedge clk_sys) begin
    if (eng_rst) begin
      start_r  <= 1'b0;
      sel_op_r <= sgcb_pkg::SGCB_OP_NONE;
      run_op_r <= sgcb_pkg::SGCB_OP_NONE;
    end else begin
      start_r <= 1'b0;
      if (!eng_busy && !start_r && !eng_done) begin
        if (lpurge_r) begin
          start_r  <= 1'b1;
          sel_op_r <= sgcb_pkg::SGCB_OP_LEARNED;
          run_op_r <= sgcb_pkg::SGCB_OP_LEARNED;
        end else if (fpurge_r) begin
          start_r  <= 1'b1;
          sel_op_r <= sgcb_pkg::SGCB_OP_FIXED;
          run_op_r <= sgcb_pkg::SGCB_OP_FIXED;
        end else if (fast_pend_r) begin
          start_r  <= 1'b1;                                                    // [R11]
          sel_op_r <= sgcb_pkg::SGCB_OP_FAST_AGE;
          run_op_r <= sgcb_pkg::SGCB_OP_FAST_AGE;
        end else if (age_pend_r) begin
          start_r  <= 1'b1;
          sel_op_r <= sgcb_pkg::SGCB_OP_AGE;
          run_op_r <= sgcb_pkg::SGCB_OP_AGE;
        end
      end
    end
  end

  sgcb_purge_engine #(
    .LEARN_DEPTH (LEARN_DEPTH),
    .FIXED_DEPTH (FIXED_DEPTH)
  ) u_engine (
    .clk_sys   (clk_sys),
    .rst       (eng_rst),
    .start     (start_r),
    .op        (sel_op_r),
    .learn_dis (learn_dis),
    .entry     (tbl_entry),
    .busy      (eng_busy),
    .done      (eng_done),
    .cmd       (tbl_cmd)
  );

  // Frame drop verdict, one cycle after the header
  always_ff @(posedge clk_sys) begin
    if (eng_rst) begin
      frm_done <= 1'b0;
      frm_drop <= 1'b0;
    end else begin
      frm_done <= frm_valid;
      if (gctl_r[`SGCB_POLICY_BIT]) begin
        frm_drop <= frm_valid && ((frm.ethertype == `SGCB_PAUSE_TYPE) ||
                                  (frm.da == `SGCB_PAUSE_DA));                 // [R9]
      end else begin
        frm_drop <= frm_valid && frm.pause_qual;                               // [R10]
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      switch_run  <= 1'b0;
      fabric_rst  <= 1'b1;
      rx_accept   <= 1'b0;
      backoff_alt <= 1'b0;
    end else begin
      switch_run  <= run_r;                                                    // [R1]
      fabric_rst  <= soft_rst;                                                 // [R2]
      rx_accept   <= run_r && !soft_rst;                                       // [R4]
      backoff_alt <= gctl_r[`SGCB_BACKOFF_BIT];                                // [R14]
    end
  end
endmodule

// ### tb/sgcb_chk.sv
`timescale 1ns/10ps
`include "sgcb_map.svh"
module sgcb_chk (
  input wire logic              clk_sys,     // System clock
  input wire logic              sys_rst,     // Synchronous reset
  input wire logic              spi_miso,    // Serial data out
  input wire logic              spi_miso_oe, // Data out drive enable
  input wire logic [4:0]        learn_dis,   // Learning disabled
  input wire logic              frm_valid,   // Frame header valid
  input sgcb_pkg::sgcb_frame_t  frm,         // Frame header fields
  input wire logic              frm_done,    // Verdict valid
  input wire logic              frm_drop,    // Verdict drop
  input wire logic              switch_run,  // Fabric forwarding enable
  input wire logic              fabric_rst,  // Fabric reset
  input wire logic              rx_accept,   // Ingress accept
  input sgcb_pkg::sgcb_tbl_cmd_t tbl_cmd,    // Table commands
  input sgcb_pkg::sgcb_entry_t  tbl_entry    // Table read data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic plain_frm;
  logic pause_frm;
  assign plain_frm = !frm.pause_qual && frm.ethertype != `SGCB_PAUSE_TYPE && frm.da != `SGCB_PAUSE_DA;
  assign pause_frm = frm.pause_qual && frm.ethertype == `SGCB_PAUSE_TYPE && frm.da == `SGCB_PAUSE_DA;
  AST_ACCEPT_GATE: assert property (rx_accept == (switch_run && !fabric_rst))
    else $error("Ingress accept disagrees with run and soft reset");
  AST_FRM_VERDICT: assert property (frm_valid |=> frm_done)
    else $error("Frame verdict missing");
  AST_KEEP_PLAIN: assert property (frm_valid && plain_frm |=> frm_done && !frm_drop)
    else $error("Ordinary frame dropped");
  AST_DROP_PAUSE: assert property (frm_valid && pause_frm |=> frm_drop)
    else $error("Pause frame kept");
  AST_DEL_SLOT: assert property (tbl_cmd.del |-> $past(tbl_cmd.rd_en, 2) && $stable(tbl_cmd.idx))
    else $error("Delete out of its slot");
  AST_ENTRY_SPACING: assert property (tbl_cmd.rd_en |=> !tbl_cmd.rd_en [*2])
    else $error("Table reads too close");
  AST_LEARNED_DEL: assert property (tbl_cmd.del && !tbl_cmd.rd_fixed |-> tbl_entry.valid && !tbl_entry.fixed)
    else $error("Bad learned delete");
  AST_FIXED_DEL: assert property (tbl_cmd.del && tbl_cmd.rd_fixed |-> tbl_entry.valid && tbl_entry.unicast
    && $onehot(tbl_entry.fwd_ports) && (tbl_entry.fwd_ports & learn_dis) != 5'h00)
    else $error("Bad fixed delete");
  AST_SOFT_HOLD: assert property (fabric_rst && $past(fabric_rst) |-> !tbl_cmd.rd_en && !tbl_cmd.del)
    else $error("Table activity in soft reset");
  AST_MISO_QUIET: assert property (!spi_miso_oe |-> !spi_miso)
    else $error("Data out active while not driven");
  COV_FIXED_DEL: cover property (tbl_cmd.del && tbl_cmd.rd_fixed);
  COV_LEARNED_DEL: cover property (tbl_cmd.del && !tbl_cmd.rd_fixed);
  COV_DROP: cover property (frm_done && frm_drop);
  COV_SOFT: cover property ($rose(fabric_rst));
endmodule
bind sgcb_top sgcb_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .spi_miso(spi_miso),
  .spi_miso_oe(spi_miso_oe), .learn_dis(learn_dis), .frm_valid(frm_valid), .frm(frm), .frm_done(frm_done),
  .frm_drop(frm_drop), .switch_run(switch_run), .fabric_rst(fabric_rst), .rx_accept(rx_accept),
  .tbl_cmd(tbl_cmd), .tbl_entry(tbl_entry));

// ### tb/tb.sv
`timescale 1ns/10ps
`include "sgcb_map.svh"
module tb;
  localparam logic [7:0] FAM   = 8'h3C; // Arbitrary value
  localparam logic [3:0] PRT   = 4'h9;  // Arbitrary value
  localparam logic [2:0] REV   = 3'h5;  // Arbitrary value
  localparam int         LDEP  = 128;
  localparam int         FDEP  = 4;
  localparam int         HALF  = 6;
  localparam int         LIMIT = 60000;
  typedef struct packed {logic pol; logic [15:0] et; logic [47:0] da; logic pq; logic drop;} sgcb_frow_t;
  logic                    clk_sys, sys_rst, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic [4:0]              link_up, learn_dis;
  logic                    frm_valid, frm_done, frm_drop, switch_run, fabric_rst, rx_accept, backoff_alt;
  sgcb_pkg::sgcb_frame_t   frm;
  sgcb_pkg::sgcb_tbl_cmd_t tbl_cmd;
  sgcb_pkg::sgcb_entry_t   tbl_entry = '0;
  sgcb_pkg::sgcb_entry_t   lrn_tab [LDEP];
  sgcb_pkg::sgcb_entry_t   fix_tab [FDEP];
  int                      num_errors = 0;
  int                      compares = 0;
  int                      cyc = 0;
  int                      nbad;
  sgcb_frow_t rows [8] = '{
    '{1'h1, 16'h8808, 48'h0000_1111_2222, 1'h0, 1'h1}, '{1'h1, 16'h0800, 48'h0180_C200_0001, 1'h0, 1'h1},
    '{1'h1, 16'h0800, 48'h0000_1111_2222, 1'h1, 1'h0}, '{1'h0, 16'h8808, 48'h0000_1111_2222, 1'h0, 1'h0},
    '{1'h0, 16'h0800, 48'h0000_1111_2222, 1'h1, 1'h1}, '{1'h0, 16'h0800, 48'h0180_C200_0001, 1'h0, 1'h0},
    '{1'h0, 16'h0800, 48'h0000_1111_2222, 1'h0, 1'h0}, '{1'h0, 16'h8808, 48'h0180_C200_0001, 1'h1, 1'h1}};
  sgcb_top #(.FAMILY_CODE(FAM), .PART_CODE(PRT), .REV_CODE(REV), .LEARN_DEPTH(LDEP), .FIXED_DEPTH(FDEP),
    .AGE_PERIOD_CYC(64'h0000_0000_000F_4240)) u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .link_up(link_up), .learn_dis(learn_dis),
    .frm_valid(frm_valid), .frm(frm), .frm_done(frm_done), .frm_drop(frm_drop), .switch_run(switch_run),
    .fabric_rst(fabric_rst), .rx_accept(rx_accept), .backoff_alt(backoff_alt), .tbl_cmd(tbl_cmd),
    .tbl_entry(tbl_entry));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Table model: data the cycle after a read; deletes clear valid
  always @(posedge clk_sys) begin
    if (tbl_cmd.rd_en)
      tbl_entry <= tbl_cmd.rd_fixed ? fix_tab[tbl_cmd.idx[1:0]] : lrn_tab[tbl_cmd.idx[6:0]];
    if (tbl_cmd.del && tbl_cmd.rd_fixed)
      fix_tab[tbl_cmd.idx[1:0]].valid <= 1'b0;
    if (tbl_cmd.del && !tbl_cmd.rd_fixed)
      lrn_tab[tbl_cmd.idx[6:0]].valid <= 1'b0;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == LIMIT) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi <= tx[i];
      repeat (HALF) @(posedge clk_sys);
      rx[i] = spi_miso;
      spi_sclk <= 1'b1;
      repeat (HALF) @(posedge clk_sys);
      spi_sclk <= 1'b0;
    end
  endtask
  task automatic reg_xfer(input logic [7:0] cmd, input logic [7:0] a, input logic [7:0] d, output logic [7:0] rd);
    logic [7:0] dummy;
    spi_cs_n <= 1'b0;
    @(posedge clk_sys);
    spi_byte(cmd, dummy);
    spi_byte(a, dummy);
    spi_byte(d, rd);
    repeat (HALF) @(posedge clk_sys);
    spi_cs_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    reg_xfer(`SGCB_SPI_CMD_WR, a, d, v);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    reg_xfer(`SGCB_SPI_CMD_RD, a, 8'h00, v);
    chk({8'h00, v}, {8'h00, exp});
  endtask
  task automatic wait_clear(input int bitn);
    logic [7:0] v;
    v = 8'hFF;
    for (int k = 0; k < 20 && v[bitn]; k++)
      reg_xfer(`SGCB_SPI_CMD_RD, 8'h02, 8'h00, v);
    chk({15'h0, v[bitn]}, 16'h0000);
  endtask
  task automatic outs(input logic [3:0] exp);
    #1;
    chk({11'h000, spi_miso_oe, switch_run, fabric_rst, rx_accept, backoff_alt}, {12'h000, exp});
    @(posedge clk_sys);
  endtask
  task complete_run;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    logic [7:0] v;
    sys_rst = 1'b1;
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    link_up = 5'h1F;
    learn_dis = 5'h05;
    frm_valid = 1'b0;
    frm = '0;
    for (int i = 0; i < LDEP; i++)
      lrn_tab[i] = '{1'h1, 1'h0, 1'h1, 1'h0, 3'(i % 5), 5'h00};
    fix_tab[0] = '{1'h1, 1'h1, 1'h1, 1'h0, 3'h0, 5'h01};
    fix_tab[1] = '{1'h1, 1'h1, 1'h1, 1'h0, 3'h0, 5'h03};
    fix_tab[2] = '{1'h1, 1'h1, 1'h0, 1'h0, 3'h0, 5'h04};
    fix_tab[3] = '{1'h1, 1'h1, 1'h1, 1'h0, 3'h0, 5'h02};
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    outs(4'hA);
    rd_chk(8'h00, FAM);
    rd_chk(8'h01, {PRT, REV, 1'h1});
    rd_chk(8'h02, 8'h0C);
    wr(8'h00, 8'hFF);
    rd_chk(8'h00, FAM);
    wr(8'h40, 8'hFF);
    rd_chk(8'h40, 8'h00);
    wr(8'h01, 8'h00);
    outs(4'h0);
    wr(8'h01, 8'hFF);
    rd_chk(8'h01, {PRT, REV, 1'h1});
    wr(8'h02, 8'h83);
    outs(4'hB);
    rd_chk(8'h02, 8'h8F);
    wr(8'h02, 8'hC3);
    outs(4'hD);
    rd_chk(8'h02, 8'hCF);
    rd_chk(8'h01, {PRT, REV, 1'h1});
    wr(8'h02, 8'h83);
    outs(4'hB);
    for (int r = 0; r < 8; r++) begin
      if (r == 0 || r == 3)
        wr(8'h02, {6'h00, rows[r].pol, 1'h0});
      frm_valid <= 1'b1;
      frm <= '{rows[r].et, rows[r].da, rows[r].pq};
      @(posedge clk_sys);
      frm_valid <= 1'b0;
      #1;
      chk({15'h0, frm_done}, 16'h0001);
      chk({15'h0, frm_drop}, {15'h0, rows[r].drop});
      @(posedge clk_sys);
    end
    wr(8'h02, 8'h20);
    rd_chk(8'h02, 8'h2C);
    wait_clear(5);
    nbad = 0;
    for (int i = 0; i < LDEP; i++)
      if (lrn_tab[i].valid !== ((i % 5) != 0 && (i % 5) != 2))
        nbad++;
    chk(16'(nbad), 16'h0000);
    wr(8'h02, 8'h10);
    wait_clear(4);
    chk({12'h000, fix_tab[3].valid, fix_tab[2].valid, fix_tab[1].valid, fix_tab[0].valid}, 16'h000E);
    wr(8'h02, 8'h01);
    link_up <= 5'h17;
    repeat (800) @(posedge clk_sys);
    nbad = 0;
    for (int i = 0; i < LDEP; i++)
      if (lrn_tab[i].valid !== 1'b0)
        nbad++;
    chk(16'(nbad), 16'h0000);
    complete_run();
  end
endmodule
